// [bench/nml_monitor.sv]
/*
 * Port checker for the navigation message loader.
 * Assumes zero wait states on APB and registered outputs, bound below.
 */
`timescale 1ns/10ps
// ==========================================================================
// Checker
module nml_monitor #(
  parameter SEC_CYCLES = 20  // Cycles per second, as in the design.
) (
  input wire       i_sys_clk,         // Clock.
  input wire       i_rst_n,           // Reset, active low.
  input wire       psel,              // APB select.
  input wire       penable,           // APB enable.
  input wire       pwrite,            // APB direction.
  input wire [7:0] paddr,             // APB address.
  input wire [31:0] pwdata,           // APB write data.
  input wire       pready,            // APB ready.
  input wire       pslverr,           // APB error.
  input wire       i_sim_running,     // Simulation state.
  input wire [1:0] o_nav_source,      // Source select.
  input wire       o_health_pass,     // Health mode.
  input wire [1:0] o_clock_issue_msb, // Clock issue top bits.
  input wire       o_fix_pulse,       // Fix sentence pulse.
  input wire       o_min_nav_pulse,   // Min-nav sentence pulse.
  input wire       o_fix_msl_height,  // Height reference.
  input wire       o_nmea_accept      // NMEA word accepted.
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Completed writes to the control and data words.
  wire acc = psel & penable & pready;
  wire ctrl_wr = acc & pwrite & (paddr == 8'h00);
  wire data_wr = acc & pwrite & (paddr == 8'h08);

  unmapped_err_a: assert property (acc && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access not refused");
  src_reset_a: assert property ($rose(i_rst_n) |-> o_nav_source == 2'h0)
    else $error("source not synthesized after reset");
  src_legal_a: assert property (o_nav_source != 2'h3)
    else $error("illegal source code");
  src_write_a: assert property (ctrl_wr |-> ##2
    o_nav_source == (($past(pwdata[1:0], 2) == 2'h3) ? 2'h0 : $past(pwdata[1:0], 2)))
    else $error("source select not taken");
  clk_msb_a: assert property (ctrl_wr |-> ##2
    o_clock_issue_msb == $past(pwdata[5:4], 2))
    else $error("clock issue bits not taken");
  health_mode_a: assert property (ctrl_wr |-> ##2
    o_health_pass == $past(pwdata[2], 2))
    else $error("health flag not taken");
  msl_height_a: assert property (o_fix_msl_height)
    else $error("height reference not sea level");
  fix_run_a: assert property (o_fix_pulse |->
    (i_sim_running || $past(i_sim_running)) ##1 !o_fix_pulse)
    else $error("fix pulse while stopped or too long");
  min_run_a: assert property (o_min_nav_pulse |->
    (i_sim_running || $past(i_sim_running)) ##1 !o_min_nav_pulse)
    else $error("min-nav pulse while stopped or too long");
  nmea_cause_a: assert property (o_nmea_accept |-> $past(data_wr) || $past(data_wr, 2))
    else $error("nmea accept without data write");

  cov_fix_c: cover property (o_fix_pulse);
  cov_nmea_c: cover property (o_nmea_accept);
  cov_err_c: cover property (acc && pslverr);
endmodule

bind nml_loader nml_monitor #(.SEC_CYCLES(SEC_CYCLES)) mon_u (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .i_sim_running(i_sim_running), .o_nav_source(o_nav_source),
  .o_health_pass(o_health_pass), .o_clock_issue_msb(o_clock_issue_msb),
  .o_fix_pulse(o_fix_pulse), .o_min_nav_pulse(o_min_nav_pulse),
  .o_fix_msl_height(o_fix_msl_height), .o_nmea_accept(o_nmea_accept));

// [bench/nml_store_model.sv]
/*
 * Model of the far side: the nonvolatile store holding the beta image and
 * the simulation state source. Assumes the bench drives i_run_req.
 */
`timescale 1ns/10ps
// ==========================================================================
// Store and simulation state model
module nml_store_model #(
  parameter [31:0] BETA = 32'h1A2B3C4D  // Stored beta words, arbitrary.
) (
  input  wire        i_sys_clk,  // System clock.
  input  wire        i_run_req,  // Bench request to run the simulation.
  output reg         o_running,  // Simulation running or relaying.
  output wire [31:0] o_beta      // Beta image from the store.
);
  assign o_beta = BETA;
  // The state follows the request one edge later, as a real sequencer would.
  initial o_running = 1'b0;
  always @(posedge i_sys_clk) begin
    o_running <= i_run_req;
  end
endmodule

// [bench/tb_top.sv]
/*
 * Self-checking bench for the navigation message loader over APB.
 * Assumes nml_consts.vh on the include path and the store model.
 */
`timescale 1ns/10ps
`include "nml_consts.vh"
// ==========================================================================
// Bench
module tb_top;
  reg         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         run_req = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata, beta;
  wire        pready, pslverr, running, fixp, minp, msl, hp, nacc;
  wire [1:0]  src, msb;
  wire [23:0] ndata;
  integer     err_count = 0, checks = 0, nfix = 0, nmin = 0, nacc_n = 0, i;
  reg  [31:0] q;
  reg         e;
  reg  [23:0] nlast;

  initial forever #2.5 clk = ~clk;

  nml_store_model store_u (.i_sys_clk(clk), .i_run_req(run_req), .o_running(running),
    .o_beta(beta));
  nml_loader #(.SEC_CYCLES(20)) dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_sim_running(running), .i_nv_beta(beta),
    .o_nav_source(src), .o_health_pass(hp), .o_clock_issue_msb(msb), .o_fix_pulse(fixp),
    .o_min_nav_pulse(minp), .o_fix_msl_height(msl), .o_nmea_accept(nacc),
    .o_nmea_data(ndata));

  // Count output pulses; they stand one cycle, so every edge is looked at.
  always @(posedge clk) begin
    if (fixp === 1'b1) nfix = nfix + 1;
    if (minp === 1'b1) nmin = nmin + 1;
    if (nacc === 1'b1) begin
      nacc_n = nacc_n + 1;
      nlast = ndata;
    end
  end

  task give_verdict;
    begin
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
        err_count = err_count + 1;
        give_verdict;
      end
    end
  endtask

  task cmd(input [3:0] op, input [5:0] sv, input [2:0] sf, input [3:0] wd, input [3:0] cnt);
    apb(1'b1, `NML_REG_CMD, {11'h000, cnt, wd, sf, sv, op});
  endtask

  task rej(input [31:0] exp);
    begin
      apb(1'b0, `NML_REG_STATUS, 32'h0);
      chk("reject flag", q[0], exp);
    end
  endtask

  task rd(input [31:0] ra, input [31:0] exp);
    begin
      apb(1'b1, `NML_REG_RDADDR, ra);
      apb(1'b0, `NML_REG_RDDATA, 32'h0);
      chk("read back", q[23:0], exp);
    end
  endtask

  task pulses(input [31:0] lo, input [31:0] hi, input [31:0] mlo, input [31:0] mhi);
    begin
      nfix = 0; nmin = 0;
      repeat (100) @(posedge clk);
      chk("fix count", nfix >= lo && nfix <= hi, 1);
      chk("min count", nmin >= mlo && nmin <= mhi, 1);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `NML_REG_CTRL, 32'h0);
    chk("source", q[1:0], 2'h0);
    apb(1'b0, `NML_REG_BETA, 32'h0);
    chk("beta", q, 32'h1A2B3C4D);
    chk("msl", msl, 1);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, `NML_REG_CTRL, i << 4);
      apb(1'b0, `NML_REG_IODC, 32'h0);
      chk("issue reg", q[9:8], i);
      chk("issue port", msb, i);
    end
    // Each bad command must raise the reject flag.
    cmd(1, 0, 3, 2, 1); rej(1);
    cmd(1, 0, 4, 1, 1); rej(1);
    cmd(1, 0, 4, 8, 3); rej(1);
    cmd(1, 0, 4, 2, 9); rej(1);
    cmd(2, 0, 2, 2, 1); rej(1);
    cmd(2, 33, 2, 2, 1); rej(1);
    cmd(2, 1, 4, 2, 1); rej(1);
    cmd(2, 1, 1, 3, 1); rej(1);
    cmd(2, 1, 2, 9, 2); rej(1);
    cmd(1, 0, 4, 2, 8); rej(0);
    for (i = 0; i < 8; i = i + 1) apb(1'b1, `NML_REG_DATA, 32'h00A00000 + i);
    cmd(2, 1, 1, 2, 1); rej(0);
    apb(1'b1, `NML_REG_DATA, 32'h00EA1000);
    cmd(2, 32, 3, 9, 1); rej(0);
    apb(1'b1, `NML_REG_DATA, 32'h005A5A5A);
    cmd(2, 1, 2, 2, 1); rej(0);
    apb(1'b1, `NML_REG_DATA, 32'h000FFE19);
    rd(0, 0);
    cmd(3, 0, 0, 0, 0);
    apb(1'b0, `NML_REG_STATUS, 32'h0);
    chk("committed", q[3], 1);
    rd(0, 24'hEA1000);
    rd(767, 24'h5A5A5A);
    rd(32'h407, 24'hA00007);
    apb(1'b1, `NML_REG_RDADDR, 32'h0);
    apb(1'b0, `NML_REG_IODC, 32'h0);
    chk("issue word", q[9:0], 10'h30F);
    rd(32'h8000, 0);
    apb(1'b1, `NML_REG_CTRL, 32'h1);
    rd(32'h8000, 24'hEA1000);
    chk("user", src, 2'h1);
    apb(1'b1, `NML_REG_CTRL, 32'h6);
    apb(1'b0, `NML_REG_CTRL, 32'h0);
    chk("live", src, 2'h2);
    chk("health", hp, 1);
    apb(1'b1, `NML_REG_RATES, 32'h0201);
    pulses(0, 0, 0, 0);
    run_req <= 1'b1;
    pulses(4, 6, 2, 3);
    apb(1'b1, `NML_REG_RATES, 32'h0);
    pulses(0, 0, 0, 0);
    nacc_n = 0;
    apb(1'b1, `NML_REG_CTRL, 32'h0);
    cmd(4, 0, 0, 0, 1);
    apb(1'b1, `NML_REG_DATA, 32'h00474741);
    repeat (3) @(posedge clk);
    chk("nmea blocked", nacc_n, 0);
    apb(1'b1, `NML_REG_CTRL, 32'h8);
    cmd(4, 0, 0, 0, 1);
    apb(1'b1, `NML_REG_DATA, 32'h00474741);
    repeat (3) @(posedge clk);
    chk("nmea taken", {nacc_n[7:0], nlast}, 32'h01474741);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", e, 1);
    give_verdict;
  end
endmodule

// [shared/nml_consts.vh]
/*
 * Constants for the navigation message loader: APB register offsets,
 * field positions, command codes, source codes and limits.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef NML_CONSTS_VH
`define NML_CONSTS_VH

// ==========================================================================
// Register byte offsets
`define NML_REG_CTRL      8'h00
`define NML_REG_CMD       8'h04
`define NML_REG_DATA      8'h08
`define NML_REG_STATUS    8'h0C
`define NML_REG_RATES     8'h10
`define NML_REG_BETA      8'h14
`define NML_REG_RDADDR    8'h18
`define NML_REG_RDDATA    8'h1C
`define NML_REG_IODC      8'h20
`define NML_REG_HEALTH    8'h24

// ==========================================================================
// Command codes in CMD[3:0]
`define NML_OP_IONO       4'h1
`define NML_OP_EPH        4'h2
`define NML_OP_COMMIT     4'h3
`define NML_OP_NMEA       4'h4

// ==========================================================================
// CTRL fields
`define NML_CTRL_SRC_LO   0
`define NML_CTRL_HLTH     2
`define NML_CTRL_PORT     3
`define NML_CTRL_CLKMSB   4

// Source select codes.
`define NML_SRC_SYNTHESIZED_SOURCE     2'h0
`define NML_SRC_USER      2'h1
`define NML_SRC_LIVE      2'h2

// ==========================================================================
// CMD fields
`define NML_CMD_SV_LO     4
`define NML_CMD_SF_LO     10
`define NML_CMD_WD_LO     13
`define NML_CMD_CNT_LO    17

// ==========================================================================
// Limits
`define NML_SF_IONO       3'h4
`define NML_SF_EPH_MAX    3'h3
`define NML_WD_MIN        4'h2
`define NML_WD_MAX        4'h9
`define NML_SV_MAX        6'h20
`define NML_CNT_MAX       4'h8
`define NML_DATA_W        24

// ==========================================================================
// Timing: one second at 200 MHz.
`define NML_CLK_HZ        200000000
`define NML_SEC_CYCLES    (`NML_CLK_HZ / 1)

`endif

// [src/nml_loader.v]
/*
 * Navigation message loader: APB register front end that validates and
 * buffers legacy navigation uploads, commits them to a nonvolatile image,
 * serves read-back and selects source, health mode and sentence timing.
 * Assumes an APB master on i_sys_clk and sim state inputs synchronous to it.
 */
// Added by the designer: the APB interface to the registers and the address map.
//
// Contract
// - Clock issue command fills top two bits
// - Lower eight bits copy ephemeris issue
// - Iono upload accepts only subframe four
// - Iono start word between two and nine
// - Up to eight words, last index nine
// - Ephemeris satellite number one to thirty-two
// - Ephemeris subframe one to three only
// - Subframe one allows words 2,6-9 only
// - Ephemeris held in RAM until commit
// - Commit copies latest uploads to store
// - Stored query returns every stored word
// - Active query returns words in use
// - Source select synthesized_source, user or live
// - Health flag zero masks, one passes
// - Fix sentence every N seconds when running
// - Min-nav sentence every N seconds when running
// - Fix sentence uses mean sea level height
// - NMEA injection needs command port selected
// - Beta coefficients stored, restored at power-on; a BETA write only sets beta_q, nothing is written to the store
`timescale 1ns/10ps
`include "nml_consts.vh"

module nml_loader #(
  parameter SEC_CYCLES = `NML_SEC_CYCLES  // Clock cycles per second.
) (
  input  wire        i_sys_clk,        // System clock, 200 MHz.
  input  wire        i_rst_n,          // Asynchronous reset, active low.
  input  wire        psel,             // APB select.
  input  wire        penable,          // APB enable.
  input  wire        pwrite,           // APB direction, high for write.
  input  wire [7:0]  paddr,            // APB byte address.
  input  wire [31:0] pwdata,           // APB write data.
  output reg  [31:0] prdata,           // APB read data.
  output reg         pready,           // APB ready.
  output reg         pslverr,          // APB error.
  input  wire        i_sim_running,    // Simulation running or relaying.
  input  wire [31:0] i_nv_beta,        // Beta words held in nonvolatile store.
  output reg  [1:0]  o_nav_source,     // Selected navigation source.
  output reg         o_health_pass,    // High: health words pass unchanged.
  output reg  [1:0]  o_clock_issue_msb,// Top bits of clock data issue.
  output reg         o_fix_pulse,      // Fix sentence request, one cycle.
  output reg         o_min_nav_pulse,  // Min-nav sentence request, one cycle.
  output reg         o_fix_msl_height, // Fix sentence height reference is MSL.
  output reg         o_nmea_accept,    // NMEA text word accepted, one cycle.
  output reg  [23:0] o_nmea_data       // Accepted NMEA text word.
);

  // ========================================================================
  // Storage: index = (sv-1)*24 + (sf-1)*8 + (wd-2); iono image kept separately.
  localparam NWORDS = 32 * 24;
  reg [23:0] eph_ram  [0:NWORDS-1];  // Temporary upload buffer.
  reg [23:0] eph_nv   [0:NWORDS-1];  // Committed image.
  reg [23:0] iono_ram [0:7];         // Iono upload buffer, words 2..9.
  reg [23:0] iono_nv  [0:7];         // Committed iono words.

  reg [31:0] ctrl_q;                 // Source, health, port, clock msb.
  reg [31:0] cmd_q;                  // Last command word.
  reg [7:0]  fix_rate_q;             // Fix sentence period, seconds.
  reg [7:0]  rmc_rate_q;             // Min-nav sentence period, seconds.
  reg [31:0] beta_q;                 // b0..b3, one byte each.
  reg        beta_load_q;            // Beta restore pending after reset.
  reg [15:0] rd_addr_q;              // Read-back word address.
  reg [3:0]  wr_cnt_q;               // Words left in the running upload.
  reg [9:0]  wr_idx_q;               // Next word index in the running upload.
  reg        wr_iono_q;              // Running upload targets iono buffer.
  reg        reject_q;               // Last command rejected, held until the next command.
  reg        commit_done_q;          // Commit performed since reset.
  reg [31:0] sec_cnt_q;              // Cycle counter for one second.
  reg [7:0]  fix_sec_q;              // Seconds since last fix sentence.
  reg [7:0]  rmc_sec_q;              // Seconds since last min-nav sentence.

  // An access is taken only in its access phase. pready is always high there
  // because the slave never inserts wait states, so the strobes leave it out.
  wire       wr_acc = psel & penable & pwrite;
  wire       rd_acc = psel & penable & ~pwrite;

  // ========================================================================
  // Command decode of pwdata for a CMD write.
  // The fields are decoded from live bus data, so they mean something only
  // in the access cycle of a CMD write; elsewhere they are ignored.
  wire [3:0] op   = pwdata[3:0];
  wire [5:0] sv   = pwdata[`NML_CMD_SV_LO +: 6];
  wire [2:0] sf   = pwdata[`NML_CMD_SF_LO +: 3];
  wire [3:0] wd   = pwdata[`NML_CMD_WD_LO +: 4];
  wire [3:0] cnt  = pwdata[`NML_CMD_CNT_LO +: 4];
  wire [4:0] last = {1'b0, wd} + {1'b0, cnt} - 5'h01;

  wire cnt_ok  = (cnt != 4'h0) && (cnt <= `NML_CNT_MAX) && (last <= {1'b0, `NML_WD_MAX});
  wire wd_ok   = (wd >= `NML_WD_MIN) && (wd <= `NML_WD_MAX);
  wire iono_ok = (sf == `NML_SF_IONO) && wd_ok && cnt_ok;
  wire sf1_wd  = (wd == 4'h2) ? (cnt == 4'h1) : (wd >= 4'h6);
  wire eph_ok  = (sv != 6'h00) && (sv <= `NML_SV_MAX) && (sf != 3'h0) &&
                 (sf <= `NML_SF_EPH_MAX) && wd_ok && cnt_ok &&
                 ((sf != 3'h1) || sf1_wd);
  // Linear index of the first word. For sv or sf of zero it wraps, which is
  // harmless because such a command is refused before the index is used.
  wire [9:0] eph_base = ({4'h0, sv - 6'h01} * 10'd24) + ({7'h0, sf - 3'h1} * 10'd8)
                        + {6'h0, wd - 4'h2};

  // ========================================================================
  // Register writes, upload sequencing and commit.
  integer i;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q        <= 32'h0;
      cmd_q         <= 32'h0;
      fix_rate_q    <= 8'h00;
      rmc_rate_q    <= 8'h00;
      beta_q        <= 32'h0;
      beta_load_q   <= 1'b1;
      rd_addr_q     <= 16'h0;
      wr_cnt_q      <= 4'h0;
      wr_idx_q      <= 10'h0;
      wr_iono_q     <= 1'b0;
      reject_q      <= 1'b0;
      commit_done_q <= 1'b0;
      o_nmea_accept <= 1'b0;
      o_nmea_data   <= 24'h0;
      // Clear both images, so that reading back a word that was never
      // uploaded gives zero and not an unknown value.
      for (i = 0; i < NWORDS; i = i + 1) begin
        eph_ram[i] <= 24'h000000;
        eph_nv[i]  <= 24'h000000;
      end
      for (i = 0; i < 8; i = i + 1) begin
        iono_ram[i] <= 24'h000000;
        iono_nv[i]  <= 24'h000000;
      end
    end else begin
      o_nmea_accept <= 1'b0;
      if (beta_load_q) begin
        beta_q      <= i_nv_beta;
        beta_load_q <= 1'b0;
      end
      if (wr_acc) begin
        case (paddr)
          `NML_REG_CTRL: begin
            ctrl_q <= pwdata;
          end
          `NML_REG_RATES: begin
            fix_rate_q <= pwdata[7:0];
            rmc_rate_q <= pwdata[15:8];
          end
          `NML_REG_BETA: begin
            beta_q      <= pwdata;
            beta_load_q <= 1'b0;
          end
          `NML_REG_RDADDR: begin
            rd_addr_q <= pwdata[15:0];
          end
          `NML_REG_CMD: begin
            cmd_q    <= pwdata;
            wr_cnt_q <= 4'h0;
            case (op)
              `NML_OP_IONO: begin
                reject_q  <= ~iono_ok;
                wr_cnt_q  <= iono_ok ? cnt : 4'h0;
                wr_idx_q  <= {6'h0, wd - 4'h2};
                wr_iono_q <= 1'b1;
              end
              `NML_OP_EPH: begin
                reject_q  <= ~eph_ok;
                wr_cnt_q  <= eph_ok ? cnt : 4'h0;
                wr_idx_q  <= eph_base;
                wr_iono_q <= 1'b0;
              end
              `NML_OP_COMMIT: begin
                // commit to store
                // The whole buffer is copied in one clock. This costs area but
                // makes the update atomic: a read never sees half an image.
                for (i = 0; i < NWORDS; i = i + 1) begin
                  eph_nv[i] <= eph_ram[i];
                end
                for (i = 0; i < 8; i = i + 1) begin
                  iono_nv[i] <= iono_ram[i];
                end
                commit_done_q <= 1'b1;
                reject_q      <= 1'b0;
              end
              `NML_OP_NMEA: begin
                reject_q <= ~ctrl_q[`NML_CTRL_PORT];
              end
              default: begin
                reject_q <= 1'b1;
              end
            endcase
          end
          // A data word with no upload pending and no text command in force
          // is dropped silently; the reject flag tells the host why only if the last command was refused.
          `NML_REG_DATA: begin
            if (wr_cnt_q != 4'h0) begin
              if (wr_iono_q) begin
                iono_ram[wr_idx_q[2:0]] <= pwdata[23:0];
              end else begin
                eph_ram[wr_idx_q] <= pwdata[23:0];
              end
              wr_cnt_q <= wr_cnt_q - 4'h1;
              wr_idx_q <= wr_idx_q + 10'h1;
            end else if (cmd_q[3:0] == `NML_OP_NMEA && ctrl_q[`NML_CTRL_PORT]) begin
              o_nmea_accept <= 1'b1;
              o_nmea_data   <= pwdata[23:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Read-back: bit 15 picks active view, bit 10 picks iono words.
  // stored view
  wire        rd_iono = rd_addr_q[10];
  wire        rd_act  = rd_addr_q[15];
  wire [9:0]  rd_idx  = rd_addr_q[9:0];
  wire        use_usr = (o_nav_source == `NML_SRC_USER);
  reg  [23:0] rd_word;
  always @* begin
    rd_word = 24'h0;
    if (rd_iono) begin
      rd_word = (rd_act && !use_usr) ? 24'h0 : iono_nv[rd_idx[2:0]];
    end else if (rd_idx < NWORDS) begin
      rd_word = (rd_act && !use_usr) ? 24'h0 : eph_nv[rd_idx];
    end
  end

  // low bits from ephemeris issue
  // Issue of data ephemeris sits in word 2 of subframe 2, top byte.
  wire [9:0]  iode_idx = {rd_idx[9:0]} + 10'd8;
  wire [7:0]  iode     = (iode_idx < NWORDS) ? eph_nv[iode_idx][23:16] : 8'h00;

  // ========================================================================
  // APB read mux and answer; zero wait states.
  // The read word is captured in the setup cycle, so prdata is settled for
  // the whole access phase and the master may take it at pready.
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `NML_REG_CTRL:   prdata <= ctrl_q;
          `NML_REG_CMD:    prdata <= cmd_q;
          `NML_REG_STATUS: prdata <= {28'h0, commit_done_q, wr_cnt_q != 4'h0,
                                      o_nmea_accept, reject_q};
          `NML_REG_RATES:  prdata <= {16'h0, rmc_rate_q, fix_rate_q};
          `NML_REG_BETA:   prdata <= beta_q;
          `NML_REG_RDADDR: prdata <= {16'h0, rd_addr_q};
          `NML_REG_RDDATA: prdata <= {8'h0, rd_word};
          `NML_REG_IODC:   prdata <= {22'h0, o_clock_issue_msb, iode};
          `NML_REG_HEALTH: prdata <= {31'h0, o_health_pass};
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end else if (psel & ~penable) begin
        case (paddr)
          `NML_REG_CTRL, `NML_REG_CMD, `NML_REG_DATA, `NML_REG_RATES,
          `NML_REG_BETA, `NML_REG_RDADDR: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ========================================================================
  // Mode outputs and sentence scheduling.
  // Mode outputs follow the control word one clock later, so software sees a
  // new mode two clocks after its write enters the access phase.
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nav_source      <= `NML_SRC_SYNTHESIZED_SOURCE;
      o_health_pass     <= 1'b0;
      o_clock_issue_msb <= 2'h0;
      o_fix_msl_height  <= 1'b1;
      o_fix_pulse       <= 1'b0;
      o_min_nav_pulse   <= 1'b0;
      sec_cnt_q         <= 32'h0;
      fix_sec_q         <= 8'h00;
      rmc_sec_q         <= 8'h00;
    end else begin
      o_nav_source      <= (ctrl_q[1:0] == 2'h3) ? `NML_SRC_SYNTHESIZED_SOURCE : ctrl_q[1:0];
      o_health_pass     <= ctrl_q[`NML_CTRL_HLTH];
      o_clock_issue_msb <= ctrl_q[`NML_CTRL_CLKMSB +: 2];
      o_fix_msl_height  <= 1'b1;
      o_fix_pulse       <= 1'b0;
      o_min_nav_pulse   <= 1'b0;
      // Counters restart whenever the simulation stops, so the first sentence
      // after a start comes one full period later, never early.
      if (!i_sim_running) begin
        sec_cnt_q <= 32'h0;
        fix_sec_q <= 8'h00;
        rmc_sec_q <= 8'h00;
      end else if (sec_cnt_q == SEC_CYCLES - 1) begin
        sec_cnt_q <= 32'h0;
        if (fix_rate_q != 8'h00 && fix_sec_q + 8'h01 >= fix_rate_q) begin
          o_fix_pulse <= 1'b1;
          fix_sec_q   <= 8'h00;
        end else begin
          fix_sec_q <= fix_sec_q + 8'h01;
        end
        if (rmc_rate_q != 8'h00 && rmc_sec_q + 8'h01 >= rmc_rate_q) begin
          o_min_nav_pulse <= 1'b1;
          rmc_sec_q       <= 8'h00;
        end else begin
          rmc_sec_q <= rmc_sec_q + 8'h01;
        end
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h1;
      end
    end
  end

endmodule
